// ===== hdl/mac_accumulator.sv
// Multiply-accumulate datapath with a 40-bit sum register behind an APB slave.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module mac_accumulator
(
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         ce,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [mac_pkg::APB_AW-1:0]   paddr,
    input  wire logic [mac_pkg::BUS_W-1:0]    pwdata,
    output logic      [mac_pkg::BUS_W-1:0]    prdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic      [mac_pkg::ACC_W-1:0]    sumOut,
    output logic      [mac_pkg::FLG_W-1:0]    flagsOut
);
    import mac_pkg::*;

    logic [ACC_W-1:0]  sumReg;
    logic [ACC_W-1:0]  sumNext;
    logic [FLG_W-1:0]  flagReg;
    logic [FLG_W-1:0]  flagNext;
    logic [CTRL_W-1:0] ctrlReg;
    logic [DATA_W-1:0] opAReg;
    logic [DATA_W-1:0] opBReg;
    logic              readyReg;
    logic              slvErrReg;
    logic [BUS_W-1:0]  rdataReg;
    logic [ACC_W-1:0]  productPrep;

    // Bus phases. The answer comes in the first access cycle.
    wire setupPhase  = psel & ~penable;
    wire accessPhase = psel & penable & readyReg & ce;

    // Address decode.
    wire selCtrl  = (paddr == OFS_CTRL);
    wire selOpA   = (paddr == OFS_OPA);
    wire selOpB   = (paddr == OFS_OPB);
    wire selCmd   = (paddr == OFS_CMD);
    wire selLow   = (paddr == OFS_LOW);
    wire selHigh  = (paddr == OFS_HIGH);
    wire selGuard = (paddr == OFS_GUARD);
    wire selFlags = (paddr == OFS_FLAGS);
    wire addrHit  = selCtrl | selOpA | selOpB | selCmd | selLow | selHigh | selGuard | selFlags;
    wire wrHit    = accessPhase & pwrite & addrHit;

    // Control word fields.
    wire shiftEn  = ctrlReg[CTRL_SHIFT_BIT];
    wire satEnReg = ctrlReg[CTRL_SAT_BIT];

    // Command decode; a write of a nonzero code to the command register runs it at once.
    wire [CMD_W-1:0] cmdCode = pwdata[CMD_W-1:0];
    wire execCmd      = wrHit & selCmd;
    wire doLoad       = execCmd & (cmdCode == CMD_LOAD);
    wire doLoadNeg    = execCmd & (cmdCode == CMD_LOAD_NEG);
    wire doLoadDbl    = execCmd & (cmdCode == CMD_LOAD_DBL);
    wire doLoadDblNeg = execCmd & (cmdCode == CMD_LOAD_DBLN);
    wire doMac        = execCmd & (cmdCode == CMD_MAC);
    wire doMacRnd     = execCmd & (cmdCode == CMD_MAC_RND);
    wire doMsub       = execCmd & (cmdCode == CMD_MSUB);
    wire anyAdd       = doMac | doMacRnd;
    wire anyMul       = anyAdd | doMsub;
    wire anyLoad      = doLoad | doLoadNeg | doLoadDbl | doLoadDblNeg;
    wire validCmd     = anyMul | anyLoad;
    wire satCapable   = validCmd & ~doLoad;

    // Load operand path.
    wire [ACC_W-1:0] loadBase = {{GUARD_W{opBReg[DATA_W-1]}}, opBReg, opAReg};
    wire loadDouble = doLoadDbl | doLoadDblNeg;
    wire loadNegate = doLoadNeg | doLoadDblNeg;
    wire [ACC_W-1:0] loadScaled = loadDouble ? {loadBase[ACC_W-2:0], 1'b0} : loadBase;
    wire [ACC_W-1:0] loadNeg    = ACC_ZERO - loadScaled;
    // Zero minus a nonzero operand always borrows.
    wire loadBorrow = |loadScaled;
    wire [ACC_W-1:0] loadRes = loadNegate ? loadNeg : loadScaled;

    mac_product u_product (
        .opA         (opAReg),
        .opB         (opBReg),
        .shiftEn     (shiftEn),
        .productPrep (productPrep)
    );

    // Multiply path, one guard bit wider than the sum register to see overflow.
    wire [ACC_W-1:0] roundAdd = doMacRnd ? ROUND_CONST : ACC_ZERO;
    wire [ACC_W:0] macSum = {sumReg[ACC_W-1], sumReg} + {productPrep[ACC_W-1], productPrep}
                            + {1'b0, roundAdd};
    wire [ACC_W:0] macDiff = {sumReg[ACC_W-1], sumReg}
                             - {productPrep[ACC_W-1], productPrep};

    // Carry is the unsigned carry out of the 40-bit addition, rounding included.
    wire [ACC_W+1:0] addWide = {2'h0, sumReg} + {2'h0, productPrep} + {2'h0, roundAdd};
    wire addCarry = |addWide[ACC_W+1:ACC_W];
    wire subBorrow = (sumReg < productPrep);

    wire [ACC_W:0] rawRes = doMsub ? macDiff
                          : anyAdd ? macSum
                          : {loadRes[ACC_W-1], loadRes};

    // Overflow shows as a guard bit that disagrees with the 40-bit sign.
    wire macOvf = anyMul & (rawRes[ACC_W] ^ rawRes[ACC_W-1]);

    // Saturation clamps to the 32-bit signed extremes, judged on the exact result.
    wire overRange  = $signed(rawRes) > $signed(SAT_MAX41);
    wire underRange = $signed(rawRes) < $signed(SAT_MIN41);
    wire satHit     = satEnReg & satCapable & (overRange | underRange);
    wire [ACC_W-1:0] satVal  = rawRes[ACC_W] ? SAT_MIN41[ACC_W-1:0] : SAT_MAX41[ACC_W-1:0];
    wire [ACC_W-1:0] clamped = satHit ? satVal : rawRes[ACC_W-1:0];

    // The low word is cleared after rounding, so the stored value is what flags see.
    wire [ACC_W-1:0] resVal = doMacRnd ? {clamped[ACC_W-1:LOW_W], {LOW_W{1'b0}}}
                            : clamped;

    // Guard bits are in use when they differ from the sign of the low 32 bits.
    wire [GUARD_W:0] topBits = resVal[ACC_W-1:ACC_W-GUARD_W-1];
    wire extUsed = ~(&topBits) & (|topBits);

    wire carryNext = anyAdd ? addCarry
                   : doMsub ? subBorrow
                   : loadNegate ? loadBorrow
                   : 1'b0;

    // Register read selection.
    wire [BUS_W-1:0] readMux =
          selCtrl  ? {{(BUS_W-CTRL_W){1'b0}}, ctrlReg}
        : selOpA   ? {{(BUS_W-DATA_W){1'b0}}, opAReg}
        : selOpB   ? {{(BUS_W-DATA_W){1'b0}}, opBReg}
        : selLow   ? {{(BUS_W-LOW_W){1'b0}}, sumReg[LOW_W-1:0]}
        : selHigh  ? {{(BUS_W-LOW_W){1'b0}}, sumReg[PROD_W-1:LOW_W]}
        : selGuard ? {{(BUS_W-GUARD_W){1'b0}}, sumReg[ACC_W-1:PROD_W]}
        : selFlags ? {{(BUS_W-FLG_W){1'b0}}, flagReg}
        : {BUS_W{1'b0}};

    assign sumNext = validCmd ? resVal : sumReg;

    // Flag update. A sticky bit set by an instruction wins over a clear in the
    // same cycle, though the bus cannot issue both at once.
    always_comb begin
        flagNext = flagReg;
        if (wrHit && selFlags) begin
            flagNext[FLG_SOVF] = flagReg[FLG_SOVF] & ~pwdata[FLG_SOVF];
            flagNext[FLG_SSAT] = flagReg[FLG_SSAT] & ~pwdata[FLG_SSAT];
        end
        if (validCmd) begin
            flagNext[FLG_OVF]   = macOvf;
            flagNext[FLG_SOVF]  = flagNext[FLG_SOVF] | macOvf;
            flagNext[FLG_SSAT]  = flagNext[FLG_SSAT] | satHit;
            flagNext[FLG_EXT]   = doLoad ? 1'b0 : extUsed;
            flagNext[FLG_CARRY] = carryNext;
            flagNext[FLG_ZERO]  = ~(|resVal);
            flagNext[FLG_NEG]   = resVal[ACC_W-1];
        end
    end

    // Bus answer registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            readyReg  <= 1'b0;
            slvErrReg <= 1'b0;
            rdataReg  <= {BUS_W{1'b0}};
        end else if (ce) begin
            readyReg  <= setupPhase;
            slvErrReg <= setupPhase & ~addrHit;
            rdataReg  <= (setupPhase & ~pwrite) ? readMux : {BUS_W{1'b0}};
        end
    end

    // Software-written registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrlReg <= CTRL_RESET;
            opAReg  <= {DATA_W{1'b0}};
            opBReg  <= {DATA_W{1'b0}};
        end else if (ce && wrHit) begin
            if (selCtrl) begin
                ctrlReg <= pwdata[CTRL_W-1:0];
            end
            if (selOpA) begin
                opAReg <= pwdata[DATA_W-1:0];
            end
            if (selOpB) begin
                opBReg <= pwdata[DATA_W-1:0];
            end
        end
    end

    // Sum register and flags.
    always_ff @(posedge clk) begin
        if (rst) begin
            sumReg  <= ACC_ZERO;
            flagReg <= FLG_RESET;
        end else if (ce) begin
            sumReg  <= sumNext;
            flagReg <= flagNext;
        end
    end

    assign prdata   = rdataReg;
    assign pready   = readyReg;
    assign pslverr  = slvErrReg;
    assign sumOut   = sumReg;
    assign flagsOut = flagReg;

    // Reference product computed apart from the datapath, for checking only.
    wire signed [PROD_W-1:0] chkProd = $signed(opAReg) * $signed(opBReg);
    wire [ACC_W-1:0] chkProd40 = {{GUARD_W{chkProd[PROD_W-1]}}, chkProd};
    wire [ACC_W-1:0] chkLoad40 = {{GUARD_W{opBReg[DATA_W-1]}}, opBReg, opAReg};
    wire [GUARD_W:0] chkTop = sumReg[ACC_W-1:ACC_W-GUARD_W-1];

    property p_mac_add;
        @(posedge clk) disable iff (rst)
        doMac && !satEnReg && !shiftEn
        |=> sumReg == $past(sumReg) + $past(chkProd40);
    endproperty
    a_mac_add: assert property (p_mac_add)
        else $error("multiply-add result differs from sum plus product");

    property p_mac_shift;
        @(posedge clk) disable iff (rst)
        doMac && !satEnReg && shiftEn
        |=> sumReg == $past(sumReg) + {$past(chkProd40[ACC_W-2:0]), 1'b0};
    endproperty
    a_mac_shift: assert property (p_mac_shift)
        else $error("shifted product not doubled before accumulation");

    property p_mac_sub;
        @(posedge clk) disable iff (rst)
        doMsub && !satEnReg && !shiftEn
        |=> sumReg == $past(sumReg) - $past(chkProd40);
    endproperty
    a_mac_sub: assert property (p_mac_sub)
        else $error("multiply-subtract result differs from sum minus product");

    property p_round_low;
        @(posedge clk) disable iff (rst)
        doMacRnd
        |=> (sumReg[LOW_W-1:0] == {LOW_W{1'b0}}) ##1 $stable(sumReg) || $changed(flagReg);
    endproperty
    a_round_low: assert property (p_round_low)
        else $error("low word not cleared after rounding multiply-add");

    property p_neg_load;
        @(posedge clk) disable iff (rst)
        doLoadNeg && !satEnReg
        |=> sumReg == ACC_ZERO - $past(chkLoad40)
            && flagReg[FLG_CARRY] == ($past(chkLoad40) != ACC_ZERO);
    endproperty
    a_neg_load: assert property (p_neg_load)
        else $error("negating load stored wrong value or borrow");

    property p_plain_load;
        @(posedge clk) disable iff (rst)
        doLoad
        |=> sumReg == $past(chkLoad40) && !flagReg[FLG_OVF] && !flagReg[FLG_EXT]
            && !flagReg[FLG_CARRY] && flagReg[FLG_SOVF] == $past(flagReg[FLG_SOVF]);
    endproperty
    a_plain_load: assert property (p_plain_load)
        else $error("plain load flags or value wrong");

    property p_zero_flag;
        @(posedge clk) disable iff (rst)
        validCmd |=> flagReg[FLG_ZERO] == (sumReg == ACC_ZERO);
    endproperty
    a_zero_flag: assert property (p_zero_flag)
        else $error("zero flag disagrees with stored sum");

    property p_neg_flag;
        @(posedge clk) disable iff (rst)
        validCmd ##1 ce |-> flagReg[FLG_NEG] == sumReg[ACC_W-1]
            && flagReg[FLG_EXT] == ($past(doLoad) ? 1'b0 : (~(&chkTop) & (|chkTop)));
    endproperty
    a_neg_flag: assert property (p_neg_flag)
        else $error("negative or extension flag disagrees with stored sum");

    property p_sticky_ovf;
        @(posedge clk) disable iff (rst)
        $fell(flagReg[FLG_SOVF]) |-> $past(wrHit && selFlags && pwdata[FLG_SOVF]);
    endproperty
    a_sticky_ovf: assert property (p_sticky_ovf)
        else $error("sticky overflow fell without a clear write");

    property p_sat_range;
        @(posedge clk) disable iff (rst)
        satEnReg && satCapable
        |=> ((&chkTop) || !(|chkTop)) && (!$past(satHit) || flagReg[FLG_SSAT]);
    endproperty
    a_sat_range: assert property (p_sat_range)
        else $error("saturated result outside 32-bit signed range");

    property p_dbl_load;
        @(posedge clk) disable iff (rst)
        doLoadDbl && !satEnReg
        |=> sumReg == {$past(chkLoad40[ACC_W-2:0]), 1'b0}
            && !flagReg[FLG_OVF] && !flagReg[FLG_CARRY];
    endproperty
    a_dbl_load: assert property (p_dbl_load)
        else $error("doubling load stored wrong value or flags");

    property p_dbln_load;
        @(posedge clk) disable iff (rst)
        doLoadDblNeg && !satEnReg
        |=> sumReg == ACC_ZERO - {$past(chkLoad40[ACC_W-2:0]), 1'b0};
    endproperty
    a_dbln_load: assert property (p_dbln_load)
        else $error("doubling negating load stored wrong value");

    // An unsigned sum that wraps below its first operand is exactly a carry out.
    property p_mac_carry;
        @(posedge clk) disable iff (rst)
        doMac && !satEnReg |=> flagReg[FLG_CARRY] == (sumReg < $past(sumReg));
    endproperty
    a_mac_carry: assert property (p_mac_carry)
        else $error("carry flag disagrees with multiply-add wrap");

    // A difference that lands above the minuend means the subtraction borrowed.
    property p_msub_borrow;
        @(posedge clk) disable iff (rst)
        doMsub && !satEnReg |=> flagReg[FLG_CARRY] == (sumReg > $past(sumReg));
    endproperty
    a_msub_borrow: assert property (p_msub_borrow)
        else $error("borrow flag disagrees with multiply-subtract result");

endmodule
`default_nettype wire

// ===== hdl/mac_pkg.sv
// Shared constants for the multiply-accumulate datapath and its register map.
package mac_pkg;

    // Datapath widths.
    localparam int DATA_W  = 16;
    localparam int PROD_W  = 32;
    localparam int ACC_W   = 40;
    localparam int GUARD_W = 8;
    localparam int LOW_W   = 16;

    // APB geometry.
    localparam int APB_AW = 8;
    localparam int BUS_W  = 32;

    // Register byte addresses.
    localparam logic [APB_AW-1:0] OFS_CTRL  = 8'h00;
    localparam logic [APB_AW-1:0] OFS_OPA   = 8'h04;
    localparam logic [APB_AW-1:0] OFS_OPB   = 8'h08;
    localparam logic [APB_AW-1:0] OFS_CMD   = 8'h0C;
    localparam logic [APB_AW-1:0] OFS_LOW   = 8'h10;
    localparam logic [APB_AW-1:0] OFS_HIGH  = 8'h14;
    localparam logic [APB_AW-1:0] OFS_GUARD = 8'h18;
    localparam logic [APB_AW-1:0] OFS_FLAGS = 8'h1C;

    // Control word fields.
    localparam int CTRL_W         = 2;
    localparam int CTRL_SHIFT_BIT = 0;
    localparam int CTRL_SAT_BIT   = 1;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;

    // Flag register fields.
    localparam int FLG_W     = 7;
    localparam int FLG_OVF   = 0;
    localparam int FLG_SOVF  = 1;
    localparam int FLG_SSAT  = 2;
    localparam int FLG_EXT   = 3;
    localparam int FLG_CARRY = 4;
    localparam int FLG_ZERO  = 5;
    localparam int FLG_NEG   = 6;
    localparam logic [FLG_W-1:0] FLG_RESET = 7'h20;

    // Command codes written to the command register; zero is no operation.
    localparam int CMD_W = 3;
    typedef enum logic [CMD_W-1:0] {
        CMD_NONE      = 3'h0,
        CMD_LOAD      = 3'h1,
        CMD_LOAD_NEG  = 3'h2,
        CMD_LOAD_DBL  = 3'h3,
        CMD_LOAD_DBLN = 3'h4,
        CMD_MAC       = 3'h5,
        CMD_MAC_RND   = 3'h6,
        CMD_MSUB      = 3'h7
    } mac_cmd_e;

    // Arithmetic constants.
    localparam logic [ACC_W-1:0] ACC_ZERO    = 40'h00_0000_0000;
    localparam logic [ACC_W-1:0] ROUND_CONST = 40'h00_0000_8000;
    localparam logic [ACC_W:0]   SAT_MAX41   = 41'h000_7FFF_FFFF;
    localparam logic [ACC_W:0]   SAT_MIN41   = 41'h1FF_8000_0000;

endpackage

// ===== hdl/mac_product.sv
// Signed 16x16 multiplier with sign extension and optional one-bit left shift.
`timescale 1ns/1ps
`default_nettype none

module mac_product
(
    input  wire logic [mac_pkg::DATA_W-1:0] opA,
    input  wire logic [mac_pkg::DATA_W-1:0] opB,
    input  wire logic                       shiftEn,
    output logic      [mac_pkg::ACC_W-1:0]  productPrep
);
    import mac_pkg::*;

    // Both operands are taken as signed, so the full 32-bit product is exact.
    wire signed [PROD_W-1:0] rawProduct = $signed(opA) * $signed(opB);

    wire [ACC_W-1:0] extProduct = {{GUARD_W{rawProduct[PROD_W-1]}}, rawProduct};

    // The shifted product always fits, since the 32-bit product has headroom in 40 bits.
    assign productPrep = shiftEn ? {extProduct[ACC_W-2:0], 1'b0} : extProduct;

endmodule
`default_nettype wire

// ===== tb/mac_host.sv
// APB master model that stands in for the processor core issuing commands.
`timescale 1ns/1ps
`default_nettype none

module mac_host
(
    input  wire logic                        clk,
    output logic                             psel,
    output logic                             penable,
    output logic                             pwrite,
    output logic      [mac_pkg::APB_AW-1:0]  paddr,
    output logic      [mac_pkg::BUS_W-1:0]   pwdata,
    input  wire logic [mac_pkg::BUS_W-1:0]   prdata,
    input  wire logic                        pready,
    input  wire logic                        pslverr
);
    import mac_pkg::*;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
    end

    // Ready is sampled at the rising edge, the same edge at which the slave takes the transfer.
    task automatic xfer(input logic isWrite, input logic [APB_AW-1:0] a,
                        input logic [BUS_W-1:0] d, output logic [BUS_W-1:0] rd,
                        output logic er);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= isWrite;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released lines carry the inverse so stale values cannot pass as fresh.
        paddr   <= ~a;
        pwdata  <= ~d;
        if (pready !== 1'b1) begin
            tb_top.err_count++;
            $display("[FAIL] %0t no ready from slave", $time);
            tb_top.results();
        end
    endtask
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the multiply-accumulate datapath.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import mac_pkg::*;

    logic              clk;
    logic              rst;
    logic              ce;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [BUS_W-1:0]  pwdata;
    logic [BUS_W-1:0]  prdata;
    logic              pready;
    logic              pslverr;
    logic [ACC_W-1:0]  sumOut;
    logic [FLG_W-1:0]  flagsOut;
    logic [ACC_W-1:0]  expSum;
    logic [FLG_W-1:0]  expFlags;
    logic [CTRL_W-1:0] ctrl;
    logic [DATA_W-1:0] opA;
    logic [DATA_W-1:0] opB;
    logic [BUS_W-1:0]  rd;
    logic              er;
    int                err_count;
    int                n_compared;

    mac_host i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    mac_accumulator i_dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sumOut(sumOut), .flagsOut(flagsOut));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [ACC_W-1:0] seen, input logic [ACC_W-1:0] want,
                       input string what);
        n_compared++;
        if (seen !== want) begin
            err_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, want);
        end
    endtask

    task automatic wr(input logic [APB_AW-1:0] a, input logic [BUS_W-1:0] d);
        i_host.xfer(1'b1, a, d, rd, er);
    endtask

    task automatic rdr(input logic [APB_AW-1:0] a);
        i_host.xfer(1'b0, a, {BUS_W{1'b0}}, rd, er);
    endtask

    // Reference arithmetic is done on a 48-bit exact value, then cut to the stored width.
    task automatic predict(input mac_cmd_e c);
        logic signed [47:0] acc, j, p, e;
        logic [ACC_W+1:0]   u;
        logic               ovf, cy;
        logic [ACC_W-1:0]   r;
        acc = {{8{expSum[39]}}, expSum};
        j = {{16{opB[15]}}, opB, opA};
        p = $signed(opA) * $signed(opB);
        if (ctrl[CTRL_SHIFT_BIT]) p = p <<< 1;
        cy = 1'b0;
        u = {2'b00, expSum} + {2'b00, p[39:0]};
        case (c)
            CMD_LOAD:      e = j;
            CMD_LOAD_NEG:  begin e = -j; cy = (j != 0); end
            CMD_LOAD_DBL:  e = j <<< 1;
            CMD_LOAD_DBLN: begin e = -(j <<< 1); cy = (j != 0); end
            CMD_MAC:       begin e = acc + p; cy = |u[ACC_W+1:ACC_W]; end
            CMD_MAC_RND:   begin
                e = acc + p + $signed({8'h00, ROUND_CONST});
                u = u + {2'b00, ROUND_CONST};
                cy = |u[ACC_W+1:ACC_W];
            end
            default:       begin e = acc - p; cy = (expSum < p[39:0]); end
        endcase
        ovf = (c >= CMD_MAC) && !(&e[47:39] || ~|e[47:39]);
        r = e[39:0];
        if (ctrl[CTRL_SAT_BIT] && c != CMD_LOAD && !(&e[47:31] || ~|e[47:31])) begin
            r = e[47] ? SAT_MIN41[39:0] : SAT_MAX41[39:0];
            expFlags[FLG_SSAT] = 1'b1;
        end
        if (c == CMD_MAC_RND) r[15:0] = 16'h0000;
        expSum = r;
        expFlags[FLG_OVF] = ovf;
        expFlags[FLG_SOVF] = expFlags[FLG_SOVF] | ovf;
        expFlags[FLG_EXT] = (c != CMD_LOAD) && !(&r[39:31] || ~|r[39:31]);
        expFlags[FLG_CARRY] = cy;
        expFlags[FLG_ZERO] = (r == ACC_ZERO);
        expFlags[FLG_NEG] = r[39];
    endtask

    task automatic op(input logic [CTRL_W-1:0] cw, input logic [DATA_W-1:0] a,
                      input logic [DATA_W-1:0] b, input mac_cmd_e c);
        ctrl = cw;
        opA = a;
        opB = b;
        wr(OFS_CTRL, {{(BUS_W-CTRL_W){1'b0}}, cw});
        wr(OFS_OPA, {16'h0000, a});
        wr(OFS_OPB, {16'h0000, b});
        wr(OFS_CMD, {{(BUS_W-CMD_W){1'b0}}, c});
        predict(c);
        @(negedge clk);
        chk(sumOut, expSum, "sum");
        chk(flagsOut, expFlags, "flags");
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        err_count = 0;
        n_compared = 0;
        expSum = ACC_ZERO;
        expFlags = FLG_RESET;
        ctrl = '0;
        opA = '0;
        opB = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(sumOut, ACC_ZERO, "reset sum");
        chk(flagsOut, FLG_RESET, "reset flags");
        rdr(OFS_CTRL);
        chk(rd, '0, "control reset");
        rdr(8'h40);
        chk(er, 1'b1, "unmapped error");
        chk(rd, '0, "unmapped data");
        op(2'h0, 16'h1234, 16'h8001, CMD_LOAD);
        op(2'h0, 16'h0000, 16'h8000, CMD_LOAD_DBL);
        op(2'h0, 16'h0001, 16'h0000, CMD_LOAD_NEG);
        op(2'h0, 16'h0000, 16'h0000, CMD_LOAD_NEG);
        op(2'h0, 16'hFFFF, 16'h7FFF, CMD_LOAD_DBLN);
        op(2'h1, 16'h8000, 16'h8000, CMD_MAC);
        op(2'h0, 16'h7FFF, 16'h7FFF, CMD_MAC_RND);
        op(2'h1, 16'h8000, 16'h7FFF, CMD_MSUB);
        op(2'h0, 16'h0000, 16'h0000, CMD_LOAD);
        op(2'h0, 16'h1234, 16'hFEDC, CMD_MAC);
        op(2'h0, 16'h8000, 16'h0003, CMD_MSUB);
        op(2'h0, 16'h7FFF, 16'h0100, CMD_MAC);
        // Walk the sum past the top of the 40-bit range, then back under the bottom.
        op(2'h0, 16'hFFFF, 16'h7FFF, CMD_LOAD_DBL);
        repeat (256) op(2'h1, 16'h8000, 16'h8000, CMD_MAC);
        repeat (260) op(2'h1, 16'h8000, 16'h8000, CMD_MSUB);
        op(2'h1, 16'h7FFF, 16'h8000, CMD_MAC_RND);
        wr(OFS_CMD, '0);
        @(negedge clk);
        chk(sumOut, expSum, "no operation");
        wr(OFS_FLAGS, 32'h0000_0006);
        expFlags[FLG_SOVF] = 1'b0;
        expFlags[FLG_SSAT] = 1'b0;
        rdr(OFS_FLAGS);
        chk(rd, {25'h000_0000, expFlags}, "sticky clear");
        op(2'h2, 16'hFFFF, 16'h7FFF, CMD_LOAD_DBL);
        op(2'h2, 16'h7FFF, 16'h7FFF, CMD_MAC_RND);
        op(2'h2, 16'h0000, 16'h8000, CMD_LOAD_NEG);
        op(2'h2, 16'h0000, 16'h8000, CMD_LOAD);
        rdr(OFS_LOW);
        chk(rd, {16'h0000, expSum[15:0]}, "low word");
        rdr(OFS_HIGH);
        chk(rd, {16'h0000, expSum[31:16]}, "high word");
        rdr(OFS_GUARD);
        chk(rd, {24'h00_0000, expSum[39:32]}, "guard bits");
        results();
    end
endmodule

`default_nettype wire
